//--- rtl/io_line_cfg_pkg.sv
package io_line_cfg_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_OUTPUT_DATA_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_PULLUP_DISABLE      = 8'h04;
	localparam logic [7:0] ADDR_PULLUP_ENABLE       = 8'h08;
	localparam logic [7:0] ADDR_PULLUP_STATUS       = 8'h0C;
	localparam logic [7:0] ADDR_PERIPH_FIRST_SELECT = 8'h10;
	localparam logic [7:0] ADDR_PERIPH_SECOND_SEL   = 8'h14;
	localparam logic [7:0] ADDR_PERIPH_SELECT_STAT  = 8'h18;
	localparam logic [7:0] ADDR_OUT_WRITE_ENABLE    = 8'h1C;
	localparam logic [7:0] ADDR_OUT_WRITE_DISABLE   = 8'h20;
	localparam logic [7:0] ADDR_OUT_WRITE_STATUS    = 8'h24;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [31:0] RST_PULLUP_ON    = 32'hFFFF_FFFF;
	localparam logic [31:0] RST_PERIPH_SEL   = 32'h0000_0000;
	localparam logic [31:0] RST_OUT_WR_EN    = 32'h0000_0000;
	localparam logic [31:0] RST_OUT_DATA     = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] pullup_on;
		logic [31:0] periph_second;
		logic [31:0] out_data;
	} line_cfg_t;

endpackage

//--- rtl/line_mask_update.sv
`timescale 1ns/1ns

// set/clear update of a per-line register
module line_mask_update #(
	parameter int WIDTH = 32
) (
	input  wire logic [WIDTH-1:0] cur,
	input  wire logic [WIDTH-1:0] set_bits,
	input  wire logic [WIDTH-1:0] clr_bits,
	output logic      [WIDTH-1:0] nxt
);

	// ****************************************
	// per-line merge
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_line
			// set beats clear on the same line
			assign nxt[i] = set_bits[i] | (cur[i] & ~clr_bits[i]);
		end
	endgenerate

endmodule // line_mask_update

//--- rtl/io_line_cfg.sv
`timescale 1ns/1ns

// Functional notes
// - Bit n of every register belongs to I/O line n, bit 0 lowest and bit 31 highest.
// - Writing one to a pull-up enable bit turns that line's pull-up on; zeros do nothing.
// - The pull-up status reads inverted: zero means pull-up on, one means off.
// - Writing one to a first-peripheral select bit gives that line to the first function.
// - Writing one to a second-peripheral select bit gives that line to the second function.
// - The select status reads zero for first-function lines and one for second-function lines.
// - Writing one to an output write enable bit lets direct data writes reach that line.
// - Writing one to an output write disable bit stops direct data writes reaching that line.
// - The output write status reads one where direct data writes take effect, else zero.
// - A direct output data write changes only lines whose output write status is one.
// - Writing one to a pull-up disable bit turns that line's pull-up off; zeros do nothing.
// - The output data status holds the value to drive on each line, zero low and one high.
module io_line_cfg #(
	parameter int LINES = 32
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic      [LINES-1:0]  pullup_on,
	output logic      [LINES-1:0]  periph_second,
	output logic      [LINES-1:0]  out_data
);

	// ****************************************
	// elaboration check
	// ****************************************
	generate
		if (LINES < 1 || LINES > 32)
		begin : g_bad_lines
			initial $error("LINES must be 1..32");
		end
	endgenerate

	// ****************************************
	// bus decode
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_ACCESS = 3'b010,
		ST_DONE   = 3'b100
	} bus_state_t;

	io_line_cfg_pkg::apb_req_t  req;
	io_line_cfg_pkg::line_cfg_t cfg;
	bus_state_t                 state_reg;
	bus_state_t                 state_next;
	logic                       wr_fire;
	logic                       rd_fire;
	logic [LINES-1:0]           wbits;
	logic [LINES-1:0]           pullup_reg;
	logic [LINES-1:0]           pullup_next;
	logic [LINES-1:0]           second_reg;
	logic [LINES-1:0]           second_next;
	logic [LINES-1:0]           owen_reg;
	logic [LINES-1:0]           owen_next;
	logic [LINES-1:0]           odata_reg;
	logic [LINES-1:0]           odata_next;
	logic [31:0]                rdata_next;
	logic                       err_next;

	assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
	assign wbits = pwdata[LINES-1:0];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, io_line_cfg_pkg::ADDR_OUTPUT_DATA_STATUS)
			| hit(a, io_line_cfg_pkg::ADDR_PULLUP_DISABLE)
			| hit(a, io_line_cfg_pkg::ADDR_PULLUP_ENABLE)
			| hit(a, io_line_cfg_pkg::ADDR_PULLUP_STATUS)
			| hit(a, io_line_cfg_pkg::ADDR_PERIPH_FIRST_SELECT)
			| hit(a, io_line_cfg_pkg::ADDR_PERIPH_SECOND_SEL)
			| hit(a, io_line_cfg_pkg::ADDR_PERIPH_SELECT_STAT)
			| hit(a, io_line_cfg_pkg::ADDR_OUT_WRITE_ENABLE)
			| hit(a, io_line_cfg_pkg::ADDR_OUT_WRITE_DISABLE)
			| hit(a, io_line_cfg_pkg::ADDR_OUT_WRITE_STATUS);
	endfunction

	// pready comes from a flop, so every access takes one wait state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (req.sel && !req.enable)
					state_next = ST_ACCESS;
			ST_ACCESS:
				if (req.sel && req.enable)
					state_next = ST_DONE;
				else
					state_next = ST_IDLE;
			ST_DONE:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end

	// a write takes effect at the edge where pready is seen high; read data is latched one edge earlier, in ST_ACCESS
	assign wr_fire = (state_reg == ST_DONE) && req.sel && req.enable && req.write;
	assign rd_fire = (state_reg == ST_ACCESS) && req.sel && req.enable && !req.write;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= ST_IDLE;
		else if (clk_en)
			state_reg <= state_next;
	end

	// ****************************************
	// line configuration
	// ****************************************
	line_mask_update #(.WIDTH(LINES)) u_pullup (
		.cur      (pullup_reg),
		.set_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_PULLUP_ENABLE)
				? wbits : '0),
		.clr_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_PULLUP_DISABLE)
				? wbits : '0),
		.nxt      (pullup_next)
	);

	line_mask_update #(.WIDTH(LINES)) u_periph (
		.cur      (second_reg),
		.set_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_PERIPH_SECOND_SEL)
				? wbits : '0),
		.clr_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_PERIPH_FIRST_SELECT)
				? wbits : '0),
		.nxt      (second_next)
	);

	line_mask_update #(.WIDTH(LINES)) u_owen (
		.cur      (owen_reg),
		.set_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_OUT_WRITE_ENABLE)
				? wbits : '0),
		.clr_bits (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_OUT_WRITE_DISABLE)
				? wbits : '0),
		.nxt      (owen_next)
	);

	// masked direct write keeps disabled lines untouched
	always_comb
	begin
		odata_next = odata_reg;
		if (wr_fire && hit(req.addr, io_line_cfg_pkg::ADDR_OUTPUT_DATA_STATUS))
			odata_next = (wbits & owen_reg) | (odata_reg & ~owen_reg);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pullup_reg <= io_line_cfg_pkg::RST_PULLUP_ON[LINES-1:0];
		else if (clk_en)
			pullup_reg <= pullup_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			second_reg <= io_line_cfg_pkg::RST_PERIPH_SEL[LINES-1:0];
		else if (clk_en)
			second_reg <= second_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			owen_reg <= io_line_cfg_pkg::RST_OUT_WR_EN[LINES-1:0];
		else if (clk_en)
			owen_reg <= owen_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			odata_reg <= io_line_cfg_pkg::RST_OUT_DATA[LINES-1:0];
		else if (clk_en)
			odata_reg <= odata_next;
	end

	// ****************************************
	// read mux
	// ****************************************
	always_comb
	begin
		rdata_next = io_line_cfg_pkg::READ_ZERO;
		err_next = !mapped(req.addr);
		case (req.addr)
			io_line_cfg_pkg::ADDR_OUTPUT_DATA_STATUS:
				rdata_next[LINES-1:0] = odata_reg;
			io_line_cfg_pkg::ADDR_PULLUP_STATUS:
				rdata_next[LINES-1:0] = ~pullup_reg;
			io_line_cfg_pkg::ADDR_PERIPH_SELECT_STAT:
				rdata_next[LINES-1:0] = second_reg;
			io_line_cfg_pkg::ADDR_OUT_WRITE_STATUS:
				rdata_next[LINES-1:0] = owen_reg;
			default:
				rdata_next = io_line_cfg_pkg::READ_ZERO;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= io_line_cfg_pkg::READ_ZERO;
		else if (clk_en && rd_fire)
			prdata <= rdata_next;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= (state_next == ST_DONE);
			pslverr <= (state_next == ST_DONE) && err_next;
		end
	end

	// ****************************************
	// line outputs
	// ****************************************
	// registered copy keeps outputs straight from flops
	assign cfg = '{pullup_on: 32'(pullup_next), periph_second: 32'(second_next),
		out_data: 32'(odata_next)};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pullup_on     <= io_line_cfg_pkg::RST_PULLUP_ON[LINES-1:0];
			periph_second <= io_line_cfg_pkg::RST_PERIPH_SEL[LINES-1:0];
			out_data      <= io_line_cfg_pkg::RST_OUT_DATA[LINES-1:0];
		end
		else if (clk_en)
		begin
			pullup_on     <= cfg.pullup_on[LINES-1:0];
			periph_second <= cfg.periph_second[LINES-1:0];
			out_data      <= cfg.out_data[LINES-1:0];
		end
	end

endmodule // io_line_cfg

//--- sim/io_line_cfg_properties.sv
`timescale 1ns/1ns
// ****************************************
// bus and line checks
// ****************************************
module io_line_cfg_properties #(
	parameter int LINES = 32
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             clk_en,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [7:0]       paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic [LINES-1:0] pullup_on,
	input wire logic [LINES-1:0] periph_second,
	input wire logic [LINES-1:0] out_data
);
	logic             wr;
	logic [LINES-1:0] wd_q;
	assign wr = psel && penable && pready && pwrite;
	// held after the write so later edges still see the data
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wd_q <= '0;
		else if (wr)
			wd_q <= pwdata[LINES-1:0];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	property p_wait; psel && !penable && clk_en ##1 clk_en |-> ##1 pready; endproperty
	a_wait: assert property (p_wait) else $error("pready not two edges after setup");
	property p_pu_en; wr && paddr == 8'h08 |-> ##[1:2] (pullup_on & wd_q) == wd_q; endproperty
	a_pu_en: assert property (p_pu_en) else $error("pull-up enable lost");
	property p_pu_dis; wr && paddr == 8'h04 |-> ##[1:2] (pullup_on & wd_q) == '0; endproperty
	a_pu_dis: assert property (p_pu_dis) else $error("pull-up disable lost");
	property p_first; wr && paddr == 8'h10 |-> ##[1:2] (periph_second & wd_q) == '0; endproperty
	a_first: assert property (p_first) else $error("first select lost");
	property p_second; wr && paddr == 8'h14 |-> ##[1:2] (periph_second & wd_q) == wd_q; endproperty
	a_second: assert property (p_second) else $error("second select lost");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rst; $rose(presetn) |-> pullup_on == '1 && periph_second == '0; endproperty
	a_rst: assert property (p_rst) else $error("bad line state after reset");
	property p_pu_rd; pready && !pwrite && paddr == 8'h0C |-> prdata[LINES-1:0] == ~pullup_on;
	endproperty
	a_pu_rd: assert property (p_pu_rd) else $error("pull-up status not inverted");
endmodule // io_line_cfg_properties

bind io_line_cfg io_line_cfg_properties #(.LINES(LINES)) io_line_cfg_properties_i (.*);

//--- sim/line_pad_model.sv
`timescale 1ns/1ns
// ****************************************
// pads and peripheral side
// ****************************************
module line_pad_model (
	input wire logic        pclk,
	input wire logic [31:0] pullup_on,
	input wire logic [31:0] periph_second,
	input wire logic [31:0] out_data,
	output logic     [31:0] pad_level
);
	logic [31:0] float_q = 32'h5555_5555;
	// released line without pull-up has no fixed level
	always_ff @(posedge pclk)
		float_q <= ~float_q;
	assign pad_level = (out_data & ~periph_second) | (periph_second & (pullup_on | float_q));
endmodule // line_pad_model

//--- sim/tb_io_line_cfg.sv
`timescale 1ns/1ns
module tb_io_line_cfg;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pullup_on, periph_second, out_data, pad_level;
	logic [31:0] pu, ps, ow, od, rd, s;
	logic [7:0]  rexp_a [5];
	int          mismatches, check_count, cycles;
	io_line_cfg io_line_cfg_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pullup_on(pullup_on),
		.periph_second(periph_second), .out_data(out_data));
	line_pad_model line_pad_model_i (.pclk(pclk), .pullup_on(pullup_on),
		.periph_second(periph_second), .out_data(out_data), .pad_level(pad_level));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [31:0] rexp(logic [7:0] a);
		case (a)
			8'h00: return od;
			8'h0C: return ~pu;
			8'h18: return ps;
			8'h24: return ow;
			default: return 32'h0000_0000;
		endcase
	endfunction
	task automatic upd(logic [7:0] a, logic [31:0] d);
		case (a)
			8'h00: od = (od & ~ow) | (d & ow);
			8'h04: pu = pu & ~d;
			8'h08: pu = pu | d;
			8'h10: ps = ps & ~d;
			8'h14: ps = ps | d;
			8'h1C: ow = ow | d;
			8'h20: ow = ow & ~d;
			default: ;
		endcase
	endtask
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// request held until pready is seen high at a rising edge
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			mismatches++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic op(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d);
		chk("wr_err", {31'h0, a > 8'h24}, {31'h0, er});
		upd(a, d);
		foreach (rexp_a[i])
		begin
			apb(1'b0, rexp_a[i], 32'h0000_0000);
			chk("rdata", rexp(rexp_a[i]), rd);
		end
		@(negedge pclk);
		chk("pullup_on", pu, pullup_on);
		chk("periph_second", ps, periph_second);
		chk("out_data", od, out_data);
		chk("pad", (od & ~ps | ps) & (~ps | pu), pad_level & (~ps | pu));
	endtask
	task automatic stop_test;
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// clock, timeout and sequence
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 9000)
		begin
			mismatches++;
			stop_test;
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		s = 32'h0000_1F2B;
		for (int k = 0; k < 2; k++)
		begin
			pu = 32'hFFFF_FFFF;
			{ps, ow, od} = '0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
			rexp_a = '{8'h00, 8'h0C, 8'h18, 8'h24, 8'h08};
			op(8'h04, 32'hFFFF_FFFF);
			op(8'h08, 32'h8000_0001);
			op(8'h14, 32'hFFFF_FFFF);
			op(8'h10, 32'h0F0F_0F0F);
			op(8'h00, 32'hA5A5_A5A5);
			op(8'h1C, 32'h0000_FFFF);
			op(8'h00, 32'hFFFF_FFFF);
			op(8'h20, 32'h0000_00FF);
			op(8'hFC, 32'hFFFF_FFFF);
			repeat (70)
			begin
				s = xs(s);
				rexp_a[4] = s[3:0] < 4'hA ? {2'b00, s[3:0], 2'b00} : 8'h28;
				s = xs(s);
				op(rexp_a[4], s);
			end
			@(posedge pclk);
			presetn <= 1'b0;
		end
		stop_test;
	end
endmodule // tb_io_line_cfg
